// *** verilog/prv_pkg.sv ***
`default_nettype none
package prv_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   // Slave tracking depth and its pointer width
   localparam int SLV_DEPTH = 4;
   localparam int SLV_PTR_W = 2;
   localparam int SLV_CNT_W = 3;
   // Slave read latency in cycles counted after the address phase ends, or after the previous pop for a queued read
   localparam logic [3:0] SLV_LAT_CYC = 4'h3;
   localparam logic [3:0] SLV_LAT_RST = 4'h0;
   // Master outstanding-read limit
   localparam int MST_MAX = 4;
   localparam int MST_CNT_W = 3;
   localparam logic [MST_CNT_W-1:0] MST_CNT_RST = 3'h0;
   localparam logic [SLV_CNT_W-1:0] SLV_CNT_RST = 3'h0;
endpackage : prv_pkg
`default_nettype wire

// *** verilog/prv_bus_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface prv_bus_if (input wire logic mclk);
   import prv_pkg::*;
   logic [ADDR_W-1:0] address;
   logic [BE_W-1:0] byteenable;
   logic read;
   logic write;
   logic [DATA_W-1:0] writedata;
   logic [DATA_W-1:0] readdata;
   logic readdatavalid;
   logic waitrequest;
   logic flush;
   modport slave (input address, byteenable, read, write, writedata, flush,
                  output readdata, readdatavalid, waitrequest);
   modport master (output address, byteenable, read, write, writedata, flush,
                   input readdata, readdatavalid, waitrequest);
endinterface : prv_bus_if
`default_nettype wire

// *** verilog/prv_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module prv_slave
(
   input wire logic mclk,
   input wire logic rst,
   prv_bus_if.slave bus,
   // Memory-side port: plain word store
   output logic [prv_pkg::ADDR_W-1:0] mem_addr,
   output logic [prv_pkg::DATA_W-1:0] mem_wdata,
   output logic [prv_pkg::BE_W-1:0] mem_be,
   output logic mem_we,
   input wire logic [prv_pkg::DATA_W-1:0] mem_rdata
);
   import prv_pkg::*;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Next slot of the circular tracking queue
   function automatic logic [SLV_PTR_W-1:0] ptr_step(input logic [SLV_PTR_W-1:0] p);
      ptr_step = p + SLV_PTR_W'(1);
   endfunction : ptr_step

   // Empty test of an occupancy count
   function automatic logic cnt_zero(input logic [SLV_CNT_W-1:0] c);
      cnt_zero = (c == SLV_CNT_RST);
   endfunction : cnt_zero

   // ------------------------------------------------------------
   // Tracking queue
   // ------------------------------------------------------------
   logic [ADDR_W-1:0] q_addr_ff [SLV_DEPTH];
   logic [SLV_PTR_W-1:0] wr_ptr_ff;
   logic [SLV_PTR_W-1:0] rd_ptr_ff;
   logic [SLV_CNT_W-1:0] cnt_ff;
   logic [3:0] age_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic rvalid_ff;
   logic wait_ff;
   logic [ADDR_W-1:0] maddr_ff;
   logic [DATA_W-1:0] mwdata_ff;
   logic [BE_W-1:0] mbe_ff;
   logic mwe_ff;

   // ------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------
   // A write seen with reads pending is stalled in its first cycle
   wire wr_block = bus.write & ~cnt_zero(cnt_ff);
   wire stall = wait_ff | wr_block;
   wire take_rd = bus.read & ~stall;
   wire take_wr = bus.write & ~stall;
   wire head_ready = ~cnt_zero(cnt_ff) && (age_ff >= SLV_LAT_CYC);
   // Discard drops every pending result except a read taken with it
   wire pop = head_ready & ~bus.flush;
   wire [SLV_CNT_W-1:0] cnt_step = cnt_ff + SLV_CNT_W'(take_rd) - SLV_CNT_W'(pop);
   wire [SLV_CNT_W-1:0] nxt_cnt = bus.flush ? SLV_CNT_W'(take_rd) : cnt_step;
   // Stall reads when full after this cycle, writes while reads remain
   wire nxt_wait = (nxt_cnt == SLV_CNT_W'(SLV_DEPTH)) | (~cnt_zero(nxt_cnt) & bus.write);
   wire [3:0] age_up = (age_ff != 4'hF) ? age_ff + 4'h1 : age_ff;
   wire [3:0] nxt_age = (pop | bus.flush | cnt_zero(cnt_ff)) ? SLV_LAT_RST : age_up;
   wire [SLV_PTR_W-1:0] nxt_rd_ptr = bus.flush ? wr_ptr_ff : (pop ? ptr_step(rd_ptr_ff) : rd_ptr_ff);
   // Memory address looks at the queue head for the next pop
   wire [ADDR_W-1:0] nxt_maddr = take_wr ? bus.address : q_addr_ff[nxt_rd_ptr];

   // ------------------------------------------------------------
   // Queue storage and pointers
   // ------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         q_addr_ff <= '{default: '0};
      end
      else if (take_rd)
      begin
         q_addr_ff[wr_ptr_ff] <= bus.address;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         wr_ptr_ff <= '0;
      end
      else if (take_rd)
      begin
         wr_ptr_ff <= ptr_step(wr_ptr_ff);
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rd_ptr_ff <= '0;
      end
      else
      begin
         rd_ptr_ff <= nxt_rd_ptr;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cnt_ff <= SLV_CNT_RST;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         age_ff <= SLV_LAT_RST;
      end
      else
      begin
         age_ff <= nxt_age;
      end
   end

   // ------------------------------------------------------------
   // Result and stall outputs
   // ------------------------------------------------------------
   // Result and strobe leave together for one cycle
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rvalid_ff <= 1'b0;
      end
      else
      begin
         rvalid_ff <= pop;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rdata_ff <= '0;
      end
      else
      begin
         rdata_ff <= pop ? mem_rdata : '0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         wait_ff <= 1'b0;
      end
      else
      begin
         wait_ff <= nxt_wait;
      end
   end

   // ------------------------------------------------------------
   // Memory side
   // ------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         mwe_ff <= 1'b0;
      end
      else
      begin
         mwe_ff <= take_wr;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         maddr_ff <= '0;
      end
      else
      begin
         maddr_ff <= nxt_maddr;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         mwdata_ff <= '0;
      end
      else
      begin
         mwdata_ff <= bus.writedata;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         mbe_ff <= '0;
      end
      else
      begin
         mbe_ff <= bus.byteenable;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign bus.readdata = rdata_ff;
   assign bus.readdatavalid = rvalid_ff;
   assign bus.waitrequest = stall;
   assign mem_addr = maddr_ff;
   assign mem_wdata = mwdata_ff;
   assign mem_be = mbe_ff;
   assign mem_we = mwe_ff;
endmodule : prv_slave
`default_nettype wire

// *** verilog/prv_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module prv_master
(
   input wire logic mclk,
   input wire logic rst,
   prv_bus_if.master bus,
   // User request side
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [prv_pkg::ADDR_W-1:0] req_addr,
   input wire logic [prv_pkg::DATA_W-1:0] req_wdata,
   input wire logic [prv_pkg::BE_W-1:0] req_be,
   input wire logic req_flush,
   output logic req_ready,
   output logic [prv_pkg::DATA_W-1:0] rsp_data,
   output logic rsp_valid
);
   import prv_pkg::*;

   // ------------------------------------------------------------
   // Request holding
   // ------------------------------------------------------------
   logic rd_ff;
   logic wr_ff;
   logic flush_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [DATA_W-1:0] wdata_ff;
   logic [BE_W-1:0] be_ff;
   logic [MST_CNT_W-1:0] pend_ff;
   logic [DATA_W-1:0] rsp_data_ff;
   logic rsp_valid_ff;
   logic ready_ff;

   wire busy = rd_ff | wr_ff;
   wire done = busy & ~bus.waitrequest;
   wire rd_done = rd_ff & ~bus.waitrequest;
   wire got = bus.readdatavalid & (pend_ff != MST_CNT_RST) & ~flush_ff;
   wire [MST_CNT_W-1:0] nxt_pend = flush_ff ? MST_CNT_W'(rd_done) : pend_ff + MST_CNT_W'(rd_done) - MST_CNT_W'(got);
   wire issue = req_valid & ready_ff;
   wire nxt_ready = (nxt_pend + MST_CNT_W'(rd_ff & ~rd_done) + MST_CNT_W'(issue & ~req_write)) < MST_CNT_W'(MST_MAX)
                    & ~(busy & ~done) & ~(issue);

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rd_ff <= 1'b0;
         wr_ff <= 1'b0;
         flush_ff <= 1'b0;
         addr_ff <= '0;
         wdata_ff <= '0;
         be_ff <= '0;
         pend_ff <= MST_CNT_RST;
         rsp_data_ff <= '0;
         rsp_valid_ff <= 1'b0;
         ready_ff <= 1'b0;
      end
      else
      begin
         if (issue)
         begin
            rd_ff <= ~req_write;
            wr_ff <= req_write;
            addr_ff <= req_addr;
            wdata_ff <= req_wdata;
            be_ff <= req_be;
         end
         else if (done)
         begin
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
         end
         // Discard pulses with the next request it rides on
         flush_ff <= issue & req_flush;
         pend_ff <= nxt_pend;
         rsp_valid_ff <= got;
         if (got)
            rsp_data_ff <= bus.readdata;
         ready_ff <= nxt_ready;
      end
   end

   assign bus.read = rd_ff;
   assign bus.write = wr_ff;
   assign bus.address = addr_ff;
   assign bus.writedata = wdata_ff;
   assign bus.byteenable = be_ff;
   assign bus.flush = flush_ff;
   assign req_ready = ready_ff;
   assign rsp_data = rsp_data_ff;
   assign rsp_valid = rsp_valid_ff;
endmodule : prv_master
`default_nettype wire

// *** sim/prv_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module prv_monitor
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [prv_pkg::ADDR_W-1:0] address,
   input wire logic [prv_pkg::BE_W-1:0] byteenable,
   input wire logic read,
   input wire logic write,
   input wire logic [prv_pkg::DATA_W-1:0] writedata,
   input wire logic readdatavalid,
   input wire logic waitrequest,
   input wire logic flush
);
   import prv_pkg::*;
   // ---------------
   // Pending count
   // ---------------
   logic [3:0] pend_ff;
   wire acc_rd = read && !waitrequest;
   always_ff @(posedge mclk)
      pend_ff <= rst ? 4'h0 : (flush ? 4'(acc_rd) : pend_ff + 4'(acc_rd) - 4'(readdatavalid));
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   hold_read_a: assert property (read && waitrequest |=> read && $stable(address) && $stable(byteenable))
      else $error("read request moved");
   hold_write_a: assert property (write && waitrequest |=> write && $stable(address) && $stable(writedata))
      else $error("write request moved");
   reset_idle_a: assert property (disable iff (1'b0) rst |=> !readdatavalid && !waitrequest)
      else $error("strobe during reset");
   queue_bound_a: assert property (pend_ff <= 4'(SLV_DEPTH))
      else $error("too many pending");
   full_stall_a: assert property (acc_rd |-> pend_ff < 4'(SLV_DEPTH) || readdatavalid)
      else $error("read taken when full");
   no_spurious_a: assert property (readdatavalid |-> pend_ff != 4'h0)
      else $error("result with none pending");
   min_latency_a: assert property (acc_rd && pend_ff == 4'h0 |=> !readdatavalid[*3])
      else $error("result too early");
   answer_due_a: assert property (acc_rd && pend_ff == 4'h0 |-> ##[2:12] readdatavalid)
      else $error("result missing");
   write_drain_a: assert property (write && !waitrequest |-> pend_ff == 4'h0 || (pend_ff == 4'h1 && readdatavalid))
      else $error("write taken with reads pending");
   flush_quiet_a: assert property (flush |=> !readdatavalid[*3])
      else $error("result soon after discard");
   cover property (acc_rd && pend_ff == 4'h2);
   cover property (write && waitrequest);
   cover property (flush && read);
endmodule : prv_monitor
`default_nettype wire

// *** sim/tb_pipelined_read_variable_latency.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_pipelined_read_variable_latency;
   import prv_pkg::*;
   typedef struct packed {logic w; logic [15:0] a; logic [31:0] d; logic [3:0] be; logic [31:0] x;} prv_row_type;
   prv_row_type rows[8] = '{'{1, 0, 32'hAAAA5555, 4'hF, 0}, '{1, 1, 32'h12345678, 4'hF, 0},
      '{1, 1, 32'hFFFFFFFF, 4'h5, 0}, '{0, 1, 0, 0, 32'h12FF56FF}, '{0, 0, 0, 0, 32'hAAAA5555},
      '{1, 2, 32'hC0DE0002, 4'hF, 0}, '{0, 2, 0, 0, 32'hC0DE0002}, '{0, 3, 0, 0, 0}};
   logic mclk = 0, rst = 1, req_valid = 0, req_write = 0, req_flush = 0, req_ready, rsp_valid, mem_we;
   logic [15:0] req_addr = 0, mem_addr;
   logic [31:0] req_wdata = 0, rsp_data, mem_wdata, mem[0:15] = '{default: 0}, got[$], exp_q[$];
   logic [3:0] req_be = 0, mem_be;
   int mismatches = 0, n_compared = 0, cyc = 0;
   always #5 mclk = ~mclk;
   prv_bus_if u_prv_bus_if (.mclk(mclk));
   prv_slave u_prv_slave (.mclk(mclk), .rst(rst), .bus(u_prv_bus_if), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_be(mem_be), .mem_we(mem_we), .mem_rdata(mem[mem_addr[3:0]]));
   prv_master u_prv_master (.mclk(mclk), .rst(rst), .bus(u_prv_bus_if), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be), .req_flush(req_flush), .req_ready(req_ready),
      .rsp_data(rsp_data), .rsp_valid(rsp_valid));
   prv_monitor u_prv_monitor (.mclk(mclk), .rst(rst), .address(u_prv_bus_if.address),
      .byteenable(u_prv_bus_if.byteenable), .read(u_prv_bus_if.read), .write(u_prv_bus_if.write),
      .writedata(u_prv_bus_if.writedata), .readdatavalid(u_prv_bus_if.readdatavalid),
      .waitrequest(u_prv_bus_if.waitrequest), .flush(u_prv_bus_if.flush));
   always @(posedge mclk)
   begin
      cyc++;
      if (rsp_valid === 1'b1) got.push_back(rsp_data);
      for (int b = 0; b < 4; b++) if (mem_we && mem_be[b]) mem[mem_addr[3:0]][8*b+:8] <= mem_wdata[8*b+:8];
      if (cyc == 3000)
      begin
         mismatches++;
         test_done();
      end
   end
   task automatic check(string n, logic [31:0] s, logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         mismatches++;
         $display("[FAIL] %s exp %h seen %h", n, e, s);
      end
   endtask : check
   task automatic issue(prv_row_type r, logic f);
      @(posedge mclk);
      {req_valid, req_write, req_addr, req_wdata, req_be, req_flush} <= {1'b1, r.w, r.a, r.d, r.be, f};
      do @(posedge mclk); while (req_ready !== 1'b1);
      req_valid <= 0;
      req_flush <= 0;
      if (f) exp_q.delete();
      if (!r.w) exp_q.push_back(r.x);
   endtask : issue
   task automatic drain();
      repeat (40) @(posedge mclk);
      check("count", got.size(), exp_q.size());
      foreach (exp_q[i]) check("rsp_data", got[i], exp_q[i]);
      got.delete();
      exp_q.delete();
   endtask : drain
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (4) @(posedge mclk);
      check("waitrequest", u_prv_bus_if.waitrequest, 0);
      check("readdatavalid", u_prv_bus_if.readdatavalid, 0);
      check("req_ready", req_ready, 0);
      rst <= 0;
      foreach (rows[i]) issue(rows[i], 0);
      drain();
      issue(rows[4], 0);
      issue(rows[6], 1);
      drain();
      test_done();
   end
endmodule : tb_pipelined_read_variable_latency
`default_nettype wire
